// >>> design/mfsc_pkg.sv
`default_nettype none

package mfsc_pkg;

   // ------------------------------------------------------------------
   // bus and register map
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 16;
   localparam logic [11:0] OFS_REF_CTRL = 12'h000;
   localparam logic [11:0] OFS_SET_A = 12'h004;
   localparam logic [11:0] OFS_SET_B = 12'h008;
   localparam logic [11:0] OFS_AMP_MODE = 12'h00c;
   localparam logic [11:0] OFS_NETWORK = 12'h010;
   localparam logic [11:0] OFS_MODE_CTRL = 12'h014;

   // writable bits; reserved bits are cleared on write and read as zero
   localparam logic [15:0] MASK_REF_CTRL = 16'h0001;
   localparam logic [15:0] MASK_SET = 16'h7f7f;
   localparam logic [15:0] MASK_NETWORK = 16'h7fff;
   localparam logic [15:0] MASK_MODE_CTRL = 16'h077f;
   localparam logic [15:0] REG_RESET = 16'h0000;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int unsigned REF_EN_BIT = 0;
   localparam int unsigned HI7_LSB = 8;
   localparam int unsigned LO7_LSB = 0;
   localparam int unsigned CMPIN_LSB = 12;
   localparam int unsigned AMPREF_LSB = 8;
   localparam int unsigned SMODE_BANK_BIT = 3;
   localparam int unsigned FLT_LOW_LSB = 12;
   localparam int unsigned FLT_HIGH_LSB = 8;
   localparam int unsigned THR_LOW_LSB = 4;
   localparam int unsigned THR_HIGH_LSB = 0;
   localparam int unsigned FUNC_LSB = 0;
   localparam int unsigned RANGE_LSB = 4;
   localparam int unsigned AGND_LSB = 8;

   // ------------------------------------------------------------------
   // codes
   // ------------------------------------------------------------------
   localparam logic [3:0] AMPREF_EXTERNAL = 4'hf;
   localparam logic [3:0] THR_NONE = 4'h7;
   localparam logic [3:0] THR_AC_MIN = 4'h8;
   localparam logic [3:0] THR_CONT_MIN = 4'hc;
   localparam logic [15:0] FLT_HIGH_UNUSED = 16'hc058;

   typedef struct packed {
      logic [15:0] set_a;
      logic [15:0] set_b;
      logic [15:0] amp_mode;
      logic [15:0] network;
   } mfsc_bank_s;

   localparam mfsc_bank_s BANK_RESET = '0;

   typedef struct packed {
      logic [6:0] amp_output_switch_bits;
      logic [6:0] power_switch_bits;
      logic [6:0] sensor_switch_bits;
      logic [6:0] feedback_switch_bits;
   } mfsc_terminal_s;

   typedef struct packed {
      logic ground_switch;
      logic high_supply_switch;
      logic low_supply_switch;
      logic amp_path_one;
      logic amp_path_two;
      logic positive_chopper_switch;
      logic negative_chopper_switch;
   } mfsc_amp_sw_s;

endpackage : mfsc_pkg

`default_nettype wire

// >>> design/mfsc_switch_config.sv
// Notes on behaviour
// RL1 - one control bit turns the voltage reference generator on or off.
// RL2 - set A bits 14..8 close amplifier output switches, one per terminal.
// RL3 - set A bits 6..0 close power switches, same terminal order.
// RL4 - set B bits 14..8 close sensor switches, one per terminal.
// RL5 - set B bits 6..0 close feedback switches, one per terminal.
// RL6 - amplifier mode bits 14..12 pick one of eight comparator inputs.
// RL7 - amplifier mode bits 11..8 pick amplifier reference; 0xf is external.
// RL8 - reference mapping depends on switch bit 3 and ground level setting.
// RL9 - switch field bits 6..4 each drive one amplifier switch directly.
// RL10 - switch bits 2..0 codes 0..4 decode to single switch controls.
// RL11 - codes 5..7 decode to combined switch and chopper controls.
// RL12 - network bits 14..12 pick one of eight pre-filter low inputs.
// RL13 - network bits 11..8 pick pre-filter high input; some codes unused.
// RL14 - network bits 7..4 low threshold, meaning split by mode; 7 inert.
// RL15 - writing function and range reloads every switch and select field.
// RL16 - software should leave auto-loaded values alone unless needed.
// RL17 - reserved bits read zero and ignore writes.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module mfsc_switch_config #(
   parameter mfsc_pkg::mfsc_bank_s PRESET [128] = '{default: '0}
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic ref_gen_en,
   output mfsc_pkg::mfsc_terminal_s terminal_switch_matrix,
   output logic [2:0] amp_direct_sw,
   output mfsc_pkg::mfsc_amp_sw_s measuring_amp_switches,
   output logic [2:0] comparator_input_sel,
   output logic [3:0] amp_reference_sel,
   output logic amp_reference_bank,
   output logic amp_reference_external,
   output logic [2:0] analog_ground_level_sel,
   output logic [2:0] prefilter_low_input_sel,
   output logic [3:0] prefilter_high_input_sel,
   output logic prefilter_high_valid,
   output logic [3:0] comparator_low_threshold_sel,
   output logic thr_cap_en,
   output logic thr_ac_en,
   output logic thr_cont_en,
   output logic [3:0] comparator_high_threshold_sel,
   output logic [3:0] measurement_function_sel,
   output logic [2:0] measurement_range_sel
);

   // ------------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------------
   function automatic mfsc_pkg::mfsc_amp_sw_s smode_decode(
      input logic [2:0] code
   );
      mfsc_pkg::mfsc_amp_sw_s s;
      s = '0;
      unique case (code)
         3'h0: s = '0;
         3'h1: s.ground_switch = 1'b1;
         3'h2: s.high_supply_switch = 1'b1;
         3'h3: s.low_supply_switch = 1'b1;
         3'h4: s.amp_path_one = 1'b1;
         3'h5: begin
            s.ground_switch = 1'b1;
            s.amp_path_one = 1'b1;
         end
         3'h6: begin
            s.high_supply_switch = 1'b1;
            s.amp_path_two = 1'b1;
            s.positive_chopper_switch = 1'b1;
         end
         3'h7: begin
            s.low_supply_switch = 1'b1;
            s.amp_path_two = 1'b1;
            s.negative_chopper_switch = 1'b1;
         end
      endcase
      return s;
   endfunction : smode_decode

   function automatic logic [15:0] write_mask(input logic [11:0] a);
      logic [15:0] m;
      m = 16'h0000;
      if (a == mfsc_pkg::OFS_REF_CTRL) begin
         m = mfsc_pkg::MASK_REF_CTRL;
      end else if (a == mfsc_pkg::OFS_SET_A || a == mfsc_pkg::OFS_SET_B ||
                   a == mfsc_pkg::OFS_AMP_MODE) begin
         m = mfsc_pkg::MASK_SET;
      end else if (a == mfsc_pkg::OFS_NETWORK) begin
         m = mfsc_pkg::MASK_NETWORK;
      end else if (a == mfsc_pkg::OFS_MODE_CTRL) begin
         m = mfsc_pkg::MASK_MODE_CTRL;
      end
      return m;
   endfunction : write_mask

   function automatic logic addr_mapped(input logic [11:0] a);
      return a == mfsc_pkg::OFS_REF_CTRL || a == mfsc_pkg::OFS_SET_A ||
             a == mfsc_pkg::OFS_SET_B || a == mfsc_pkg::OFS_AMP_MODE ||
             a == mfsc_pkg::OFS_NETWORK || a == mfsc_pkg::OFS_MODE_CTRL;
   endfunction : addr_mapped

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [15:0] ref_ctrl_q;
   logic [15:0] ref_ctrl_d;
   logic [15:0] mode_ctrl_q;
   logic [15:0] mode_ctrl_d;
   mfsc_pkg::mfsc_bank_s bank_q;
   mfsc_pkg::mfsc_bank_s bank_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------
   wire logic setup_ph = psel && !penable;
   wire logic access_ph = psel && penable;
   wire logic hit = addr_mapped(paddr);
   wire logic wr_en = access_ph && pwrite && hit;
   wire logic [15:0] wmask = write_mask(paddr);
   wire logic [15:0] wval = pwdata[15:0] & wmask; // RL17
   wire logic wr_ref = wr_en && paddr == mfsc_pkg::OFS_REF_CTRL;
   wire logic wr_a = wr_en && paddr == mfsc_pkg::OFS_SET_A;
   wire logic wr_b = wr_en && paddr == mfsc_pkg::OFS_SET_B;
   wire logic wr_amp = wr_en && paddr == mfsc_pkg::OFS_AMP_MODE;
   wire logic wr_net = wr_en && paddr == mfsc_pkg::OFS_NETWORK;
   wire logic wr_mode = wr_en && paddr == mfsc_pkg::OFS_MODE_CTRL;

   // preset index is {function, range} taken from the write itself
   wire logic [6:0] preset_idx = {wval[mfsc_pkg::FUNC_LSB +: 4],
                                  wval[mfsc_pkg::RANGE_LSB +: 3]};

   // zero wait states; errors only on unmapped words
   assign pready = 1'b1;
   assign pslverr = access_ph && !hit;
   assign prdata = prdata_q;

   // ------------------------------------------------------------------
   // next-state selection
   // ------------------------------------------------------------------
   assign ref_ctrl_d = wr_ref ? wval : ref_ctrl_q; // RL1
   assign mode_ctrl_d = wr_mode ? wval : mode_ctrl_q;

   // a mode write replaces the whole bank; software may retune afterwards
   always_comb begin
      bank_d = bank_q;
      if (wr_mode) begin
         bank_d = PRESET[preset_idx]; // RL15
         bank_d.set_a = bank_d.set_a & mfsc_pkg::MASK_SET; // RL17
         bank_d.set_b = bank_d.set_b & mfsc_pkg::MASK_SET;
         bank_d.amp_mode = bank_d.amp_mode & mfsc_pkg::MASK_SET;
         bank_d.network = bank_d.network & mfsc_pkg::MASK_NETWORK;
      end
      if (wr_a) begin
         bank_d.set_a = wval; // RL2 RL3
      end
      if (wr_b) begin
         bank_d.set_b = wval; // RL4 RL5
      end
      if (wr_amp) begin
         bank_d.amp_mode = wval;
      end
      if (wr_net) begin
         bank_d.network = wval;
      end
   end

   // read data is captured in the setup phase so it is a flop output
   always_comb begin
      prdata_d = prdata_q;
      if (setup_ph) begin
         prdata_d = 32'h0000_0000;
         if (paddr == mfsc_pkg::OFS_REF_CTRL) begin
            prdata_d[15:0] = ref_ctrl_q;
         end else if (paddr == mfsc_pkg::OFS_SET_A) begin
            prdata_d[15:0] = bank_q.set_a;
         end else if (paddr == mfsc_pkg::OFS_SET_B) begin
            prdata_d[15:0] = bank_q.set_b;
         end else if (paddr == mfsc_pkg::OFS_AMP_MODE) begin
            prdata_d[15:0] = bank_q.amp_mode;
         end else if (paddr == mfsc_pkg::OFS_NETWORK) begin
            prdata_d[15:0] = bank_q.network;
         end else if (paddr == mfsc_pkg::OFS_MODE_CTRL) begin
            prdata_d[15:0] = mode_ctrl_q;
         end
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         ref_ctrl_q <= mfsc_pkg::REG_RESET;
         mode_ctrl_q <= mfsc_pkg::REG_RESET;
         bank_q <= mfsc_pkg::BANK_RESET;
         prdata_q <= 32'h0000_0000;
      end else begin
         ref_ctrl_q <= ref_ctrl_d;
         mode_ctrl_q <= mode_ctrl_d;
         bank_q <= bank_d;
         prdata_q <= prdata_d;
      end
   end

   // ------------------------------------------------------------------
   // switch matrix and selector outputs
   // ------------------------------------------------------------------
   assign ref_gen_en = ref_ctrl_q[mfsc_pkg::REF_EN_BIT]; // RL1
   // bit 6 is the negative supply terminal, bits 5..0 terminals 5..0
   assign terminal_switch_matrix = '{
      amp_output_switch_bits: bank_q.set_a[mfsc_pkg::HI7_LSB +: 7], // RL2
      power_switch_bits: bank_q.set_a[mfsc_pkg::LO7_LSB +: 7], // RL3
      sensor_switch_bits: bank_q.set_b[mfsc_pkg::HI7_LSB +: 7], // RL4
      feedback_switch_bits: bank_q.set_b[mfsc_pkg::LO7_LSB +: 7] // RL5
   };

   wire logic [6:0] amp_switch_field = bank_q.amp_mode[mfsc_pkg::LO7_LSB +: 7];
   assign amp_direct_sw = amp_switch_field[6:4]; // RL9
   assign measuring_amp_switches =
      smode_decode(amp_switch_field[2:0]); // RL10 RL11

   assign comparator_input_sel =
      bank_q.amp_mode[mfsc_pkg::CMPIN_LSB +: 3]; // RL6
   assign amp_reference_sel =
      bank_q.amp_mode[mfsc_pkg::AMPREF_LSB +: 4]; // RL7
   // the analog side maps code and bank to a source; only 0xf is bank-free
   assign amp_reference_bank =
      amp_switch_field[mfsc_pkg::SMODE_BANK_BIT]; // RL8
   assign amp_reference_external =
      amp_reference_sel == mfsc_pkg::AMPREF_EXTERNAL; // RL7
   assign analog_ground_level_sel =
      mode_ctrl_q[mfsc_pkg::AGND_LSB +: 3]; // RL8

   assign prefilter_low_input_sel =
      bank_q.network[mfsc_pkg::FLT_LOW_LSB +: 3]; // RL12
   assign prefilter_high_input_sel =
      bank_q.network[mfsc_pkg::FLT_HIGH_LSB +: 4];
   // unassigned codes leave every high-side input open
   assign prefilter_high_valid =
      !mfsc_pkg::FLT_HIGH_UNUSED[prefilter_high_input_sel]; // RL13

   assign comparator_low_threshold_sel =
      bank_q.network[mfsc_pkg::THR_LOW_LSB +: 4];
   assign comparator_high_threshold_sel =
      bank_q.network[mfsc_pkg::THR_HIGH_LSB +: 4];
   assign thr_cap_en =
      comparator_low_threshold_sel < mfsc_pkg::THR_NONE; // RL14
   assign thr_ac_en = comparator_low_threshold_sel >= mfsc_pkg::THR_AC_MIN &&
                      comparator_low_threshold_sel < mfsc_pkg::THR_CONT_MIN;
   assign thr_cont_en =
      comparator_low_threshold_sel >= mfsc_pkg::THR_CONT_MIN; // RL14

   assign measurement_function_sel = mode_ctrl_q[mfsc_pkg::FUNC_LSB +: 4];
   assign measurement_range_sel = mode_ctrl_q[mfsc_pkg::RANGE_LSB +: 3];

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence ref_write_s;
      wr_ref;
   endsequence

   sequence mode_write_s;
      wr_mode;
   endsequence

   ref_enable_follow_a: assert property ( // RL1
      ref_write_s |=> ref_gen_en == $past(pwdata[0]))
      else $error("reference enable did not follow write");

   ref_enable_hold_a: assert property ( // RL1
      !wr_ref |=> $stable(ref_gen_en))
      else $error("reference enable changed without write");

   set_a_fields_a: assert property ( // RL2
      wr_a |=> terminal_switch_matrix.amp_output_switch_bits ==
               $past(pwdata[14:8]))
      else $error("amplifier output switches wrong after write");

   power_fields_a: assert property ( // RL3
      wr_a |=> terminal_switch_matrix.power_switch_bits == $past(pwdata[6:0]))
      else $error("power switches wrong after write");

   set_b_fields_a: assert property ( // RL4
      wr_b |=> terminal_switch_matrix.sensor_switch_bits == $past(pwdata[14:8])
               && terminal_switch_matrix.feedback_switch_bits ==
               $past(pwdata[6:0]))
      else $error("sensor or feedback switches wrong"); // RL5

   cmp_input_a: assert property ( // RL6
      wr_amp |=> comparator_input_sel == $past(pwdata[14:12]))
      else $error("comparator input select wrong");

   ext_ref_a: assert property ( // RL7
      amp_reference_external == (bank_q.amp_mode[11:8] == 4'hf))
      else $error("external reference flag wrong");

   ref_bank_a: assert property ( // RL8
      wr_amp |=> amp_reference_bank == $past(pwdata[3]))
      else $error("reference bank bit wrong");

   direct_sw_a: assert property ( // RL9
      wr_amp |=> amp_direct_sw == $past(pwdata[6:4]))
      else $error("direct amplifier switches wrong");

   single_decode_a: assert property ( // RL10
      amp_switch_field[2:0] == 3'h4 |->
      measuring_amp_switches == 7'b0001000)
      else $error("code four decode wrong");

   none_decode_a: assert property ( // RL10
      amp_switch_field[2:0] == 3'h0 |-> measuring_amp_switches == 7'h00)
      else $error("code zero closes a switch");

   combo_decode_a: assert property ( // RL11
      amp_switch_field[2:0] == 3'h6 |-> measuring_amp_switches == 7'b0100110)
      else $error("code six decode wrong");

   filter_low_a: assert property ( // RL12
      wr_net |=> prefilter_low_input_sel == $past(pwdata[14:12]))
      else $error("pre-filter low select wrong");

   filter_high_a: assert property ( // RL13
      prefilter_high_input_sel == 4'h5 |-> prefilter_high_valid)
      else $error("temperature input flagged invalid");

   thr_inert_a: assert property ( // RL14
      comparator_low_threshold_sel == 4'h7 |->
      !(thr_cap_en || thr_ac_en || thr_cont_en))
      else $error("threshold code seven is active");

   autoload_a: assert property ( // RL15
      mode_write_s |=> bank_q.set_a ==
         ($past(PRESET[preset_idx].set_a) & 16'h7f7f) ##1
         (bank_q.set_a == $past(bank_q.set_a) || $past(wr_a)))
      else $error("bank not loaded on mode write");

   reserved_zero_a: assert property ( // RL17
      bank_q.set_a[15] == 1'b0 && bank_q.set_a[7] == 1'b0 &&
      bank_q.set_b[15] == 1'b0 && bank_q.set_b[7] == 1'b0 &&
      bank_q.amp_mode[15] == 1'b0 && bank_q.amp_mode[7] == 1'b0 &&
      bank_q.network[15] == 1'b0)
      else $error("reserved bit set");

   unmapped_err_a: assert property (
      access_ph && !hit |-> pslverr ##1 $stable(bank_q))
      else $error("unmapped access not refused");

endmodule : mfsc_switch_config

`default_nettype wire

// >>> dv/tb_meter_frontend_switch_config.sv
`timescale 1ns/1ps
`default_nettype none

module tb_meter_frontend_switch_config;

   // ------------------------------------------------------------------
   // preset table: one populated mode, {function 2, range 5} is index 21
   // ------------------------------------------------------------------
   localparam mfsc_pkg::mfsc_bank_s P21 = '{set_a: 16'hffff,
      set_b: 16'h1234, amp_mode: 16'h8abc, network: 16'hfedc};
   localparam mfsc_pkg::mfsc_bank_s PRESET_T [128] =
      '{21: P21, default: '0};

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, ref_gen_en, amp_ref_bank, amp_ref_ext;
   logic flt_hi_valid, thr_cap_en, thr_ac_en, thr_cont_en;
   mfsc_pkg::mfsc_terminal_s term;
   mfsc_pkg::mfsc_amp_sw_s amp_sw;
   logic [2:0] amp_direct_sw, cmp_in, agnd, flt_lo, range_sel;
   logic [3:0] amp_ref, flt_hi, thr_lo, thr_hi, func_sel;
   logic [31:0] rdv;
   logic errv;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   // decoder outputs, ground switch first down to negative chopper
   logic [6:0] dec_tab [8] = '{7'h00, 7'h40, 7'h20, 7'h10,
                               7'h08, 7'h48, 7'h26, 7'h15};

   mfsc_switch_config #(.PRESET(PRESET_T)) dut_u (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ref_gen_en(ref_gen_en), .terminal_switch_matrix(term),
      .amp_direct_sw(amp_direct_sw), .measuring_amp_switches(amp_sw),
      .comparator_input_sel(cmp_in), .amp_reference_sel(amp_ref),
      .amp_reference_bank(amp_ref_bank),
      .amp_reference_external(amp_ref_ext),
      .analog_ground_level_sel(agnd), .prefilter_low_input_sel(flt_lo),
      .prefilter_high_input_sel(flt_hi),
      .prefilter_high_valid(flt_hi_valid),
      .comparator_low_threshold_sel(thr_lo), .thr_cap_en(thr_cap_en),
      .thr_ac_en(thr_ac_en), .thr_cont_en(thr_cont_en),
      .comparator_high_threshold_sel(thr_hi),
      .measurement_function_sel(func_sel),
      .measurement_range_sel(range_sel));

   initial begin
      forever #50 clk = ~clk;
   end

   // ------------------------------------------------------------------
   // closing report and hang guard
   // ------------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors = errors + 1;
         summarize();
      end
   end

   // ------------------------------------------------------------------
   // bus and compare helpers
   // ------------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask : chk

   // one apb transfer; the edge before release holds read data and error
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : xfer

   task automatic rd_chk(input string what, input logic [11:0] a,
                         input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk(what, exp, rdv);
      chk("slave error", 32'h0000_0000, {31'h0, errv});
   endtask : rd_chk

   // ------------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd_chk("reset value", 12'(i * 4), 32'h0000_0000);
      end
      chk("idle threshold flag", 32'h1, {31'h0, thr_cap_en});
      xfer(1'b1, 12'h01c, 32'h0000_ffff);
      chk("unmapped write error", 32'h1, {31'h0, errv});
      xfer(1'b0, 12'h018, 32'h0000_0000);
      chk("unmapped read error", 32'h1, {31'h0, errv});
      chk("unmapped read data", 32'h0000_0000, rdv);
      rd_chk("set a untouched", mfsc_pkg::OFS_SET_A, 32'h0000_0000);
      $display("test reset_and_unmapped done");

      xfer(1'b1, mfsc_pkg::OFS_REF_CTRL, 32'hffff_ffff);
      chk("ref enable on", 32'h1, {31'h0, ref_gen_en});
      rd_chk("ref ctrl", mfsc_pkg::OFS_REF_CTRL, 32'h1);
      xfer(1'b1, mfsc_pkg::OFS_REF_CTRL, 32'h0000_fffe);
      chk("ref enable off", 32'h0, {31'h0, ref_gen_en});
      $display("test reference_enable done");

      for (int b = 0; b < 7; b++) begin
         xfer(1'b1, mfsc_pkg::OFS_SET_A, 32'(16'h0100 << b | 1 << (6 - b)));
         chk("amp out", 32'(1 << b), 32'(term.amp_output_switch_bits));
         chk("power", 32'(1 << (6 - b)), 32'(term.power_switch_bits));
         xfer(1'b1, mfsc_pkg::OFS_SET_B, 32'(16'h0100 << (6 - b) | 1 << b));
         chk("sensor", 32'(1 << (6 - b)), 32'(term.sensor_switch_bits));
         chk("feedback", 32'(1 << b), 32'(term.feedback_switch_bits));
      end
      xfer(1'b1, mfsc_pkg::OFS_SET_A, 32'hffff_ffff);
      rd_chk("set a masked", mfsc_pkg::OFS_SET_A, 32'h0000_7f7f);
      xfer(1'b1, mfsc_pkg::OFS_SET_B, 32'h0000_ffff);
      rd_chk("set b masked", mfsc_pkg::OFS_SET_B, 32'h0000_7f7f);
      $display("test terminal_switches done");

      for (int i = 0; i < 8; i++) begin
         logic [3:0] rv;
         logic [15:0] wv;
         rv = 4'(2 * i + 1);
         wv = {1'b1, 3'(i), rv, 1'b1, 3'(7 - i), i[0], 3'(i)};
         xfer(1'b1, mfsc_pkg::OFS_AMP_MODE, {16'h0000, wv});
         chk("comparator input", 32'(i), 32'(cmp_in));
         chk("amp reference", 32'(rv), 32'(amp_ref));
         chk("external ref", 32'(i == 7), 32'(amp_ref_ext));
         chk("reference bank", 32'(i[0]), 32'(amp_ref_bank));
         chk("direct switches", 32'(7 - i), 32'(amp_direct_sw));
         chk("switch decode", 32'(dec_tab[i]), 32'(amp_sw));
         rd_chk("amp", mfsc_pkg::OFS_AMP_MODE, 32'(wv & 16'h7f7f));
      end
      $display("test amplifier_mode done");

      for (int i = 0; i < 16; i++) begin
         logic [15:0] wv;
         logic hv;
         // unassigned high-side codes must report no valid input
         hv = !(i inside {3, 4, 6, 14, 15});
         wv = {1'b1, 3'(i), 4'(i), 4'(i), ~4'(i)};
         xfer(1'b1, mfsc_pkg::OFS_NETWORK, {16'h0000, wv});
         chk("prefilter low", 32'(i % 8), 32'(flt_lo));
         chk("prefilter high", 32'(i), 32'(flt_hi));
         chk("high valid", 32'(hv), 32'(flt_hi_valid));
         chk("low threshold", 32'(i), 32'(thr_lo));
         chk("cap flag", 32'(i < 7), 32'(thr_cap_en));
         chk("ac flag", 32'(i >= 8 && i <= 11), 32'(thr_ac_en));
         chk("cont flag", 32'(i >= 12), 32'(thr_cont_en));
         chk("high threshold", {28'h0, ~4'(i)}, 32'(thr_hi));
         rd_chk("network", mfsc_pkg::OFS_NETWORK, 32'(wv & 16'h7fff));
      end
      $display("test network_select done");

      xfer(1'b1, mfsc_pkg::OFS_MODE_CTRL, 32'h0000_8352);
      chk("function", 32'h2, 32'(func_sel));
      chk("range", 32'h5, 32'(range_sel));
      chk("ground level", 32'h3, 32'(agnd));
      chk("loaded amp out", 32'h7f, 32'(term.amp_output_switch_bits));
      chk("loaded decode", 32'(dec_tab[4]), 32'(amp_sw));
      chk("loaded threshold", 32'hd, 32'(thr_lo));
      rd_chk("mode ctrl", mfsc_pkg::OFS_MODE_CTRL, 32'h0000_0352);
      rd_chk("loaded set a", mfsc_pkg::OFS_SET_A, 32'h0000_7f7f);
      rd_chk("loaded set b", mfsc_pkg::OFS_SET_B, 32'h0000_1234);
      rd_chk("loaded amp", mfsc_pkg::OFS_AMP_MODE, 32'h0000_0a3c);
      rd_chk("loaded net", mfsc_pkg::OFS_NETWORK, 32'h0000_7edc);
      // software may still override after the automatic load
      xfer(1'b1, mfsc_pkg::OFS_SET_B, 32'h0000_0001);
      rd_chk("override set b", mfsc_pkg::OFS_SET_B, 32'h0000_0001);
      xfer(1'b1, mfsc_pkg::OFS_MODE_CTRL, 32'h0000_0000);
      for (int i = 1; i < 5; i++) begin
         rd_chk("cleared bank", 12'(i * 4), 32'h0000_0000);
      end
      chk("cleared terminals", 32'h0, 32'(term));
      $display("test auto_load done");
      summarize();
   end

endmodule : tb_meter_frontend_switch_config

`default_nettype wire
